//--- include/mmu_attr_consts.vh
// Register offsets, field positions, reset values and encodings of the MMU response block.
`ifndef MMU_ATTR_CONSTS_VH
`define MMU_ATTR_CONSTS_VH

// ==========================================================================
// Register byte offsets
`define OFS_CTRL 5'h00
`define OFS_WALK_ATTR 5'h04
`define OFS_FAULT_LO 5'h08
`define OFS_FAULT_HI 5'h0c
`define OFS_STATUS 5'h10

// ==========================================================================
// Control register fields
`define CTRL_ATTR_EN 0
`define CTRL_S1_ATTR_EN_LO 1
`define CTRL_S2_ATTR_EN_LO 3
`define CTRL_STAGE1_EN 5
`define CTRL_STAGE2_EN 6
`define CTRL_ICACHE_EN 7
`define CTRL_RESET 8'h00

// ==========================================================================
// Walk attribute register fields
`define WALK_HYP_LO 0
`define WALK_S1_LO 2
`define WALK_S2_LO 4
`define WALK_RESET 6'h00

// ==========================================================================
// Status register fields
`define STAT_SYNC 0
`define STAT_ASYNC 1
`define STAT_CLASS_LO 4

// ==========================================================================
// Translation sources
`define SRC_L1_HIT 2'h0
`define SRC_L2_HIT 2'h1
`define SRC_WALK 2'h2

// ==========================================================================
// Walk regimes
`define REGIME_HYP 2'h0
`define REGIME_S1 2'h1
`define REGIME_S2 2'h2

// ==========================================================================
// Device memory types
`define DEV_NGNRNE 2'h0
`define DEV_NGNRE 2'h1
`define DEV_NGRE 2'h2
`define DEV_GRE 2'h3

// ==========================================================================
// External abort access classes
`define ABT_WALK 3'h0
`define ABT_LOAD 3'h1
`define ABT_LOAD_ACQ 3'h2
`define ABT_ATOMIC 3'h3
`define ABT_STORE 3'h4
`define ABT_CMO 3'h5
`define ABT_TLBI 3'h6
`define ABT_ICINV 3'h7

// ==========================================================================
// Avalon answers
`define RESP_OKAY 2'h0
`define RESP_DECODEERR 2'h3

`endif

//--- rtl/mmu_response_attr_page_hw_attr_bits.v
// MMU translation response, memory attribute, abort and page attribute logic.
//
// Register access over Avalon-MM and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "mmu_attr_consts.vh"

module mmu_response_attr_page_hw_attr_bits #(
  parameter PA_W = 48,
  parameter ATTR_W = 2
) (
  input wire clk,
  input wire reset,
  input wire [4:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  output reg [1:0] avs_response,
  input wire xlat_done,
  input wire [1:0] xlat_source,
  input wire xlat_requester,
  input wire [PA_W-1:0] xlat_pa,
  input wire [3:0] xlat_perm,
  input wire xlat_ns,
  input wire xlat_fault,
  input wire [5:0] xlat_fault_code,
  input wire xlat_range_fault,
  input wire contiguous_hint_bit,
  input wire [7:0] xlat_mem_attr,
  output reg resp_valid,
  output reg [1:0] resp_source,
  output reg resp_requester,
  output reg [PA_W-1:0] resp_pa,
  output reg [3:0] resp_perm,
  output reg resp_ns,
  output reg resp_fault,
  output reg [5:0] resp_fault_code,
  output reg resp_device,
  output reg [1:0] resp_dev_type,
  output reg resp_cacheable,
  output reg resp_alloc_icache,
  output reg resp_alloc_unified,
  input wire mem_txn_valid,
  input wire mem_txn_walk,
  input wire [1:0] mem_walk_regime,
  input wire [ATTR_W-1:0] mem_s1_attr,
  input wire [ATTR_W-1:0] mem_s2_attr,
  output reg mem_out_valid,
  output reg [ATTR_W-1:0] page_hw_attr_bits,
  input wire ext_abort,
  input wire [2:0] ext_abort_class,
  input wire ext_abort_device,
  input wire [PA_W-1:0] ext_abort_addr,
  output reg sync_abort,
  output reg async_abort
);

  // ========================================================================
  // Register state
  reg [7:0] ctrl;
  reg [5:0] walk_attr;
  reg [PA_W-1:0] fault_addr;
  reg sync_flag;
  reg async_flag;
  reg [2:0] last_class;
  reg ack;

  wire bus_req;
  wire bus_done;
  wire [4:0] word_addr;
  wire addr_hit;
  wire [63:0] fault_wide;

  // ========================================================================
  // Avalon slave: one wait state, then the answer with waitrequest low.
  assign bus_req = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~ack;
  assign bus_done = bus_req & ack;
  assign word_addr = {avs_address[4:2], 2'b00};
  assign addr_hit = (word_addr == `OFS_CTRL) || (word_addr == `OFS_WALK_ATTR) ||
                    (word_addr == `OFS_FAULT_LO) || (word_addr == `OFS_FAULT_HI) ||
                    (word_addr == `OFS_STATUS);
  assign fault_wide = {{(64-PA_W){1'b0}}, fault_addr};

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      ack <= 1'b0;
    end else begin
      ack <= bus_req & ~ack;
    end
  end

  // Read data and the answer code are latched in the wait cycle so that
  // they stand at the edge where waitrequest is low.
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      avs_readdata <= 32'h00000000;
      avs_response <= `RESP_OKAY;
    end else if (bus_req & ~ack) begin
      avs_response <= addr_hit ? `RESP_OKAY : `RESP_DECODEERR;
      avs_readdata <= 32'h00000000;
      if (avs_read) begin
        case (word_addr)
          `OFS_CTRL: avs_readdata <= {24'h000000, ctrl};
          `OFS_WALK_ATTR: avs_readdata <= {26'h0000000, walk_attr};
          `OFS_FAULT_LO: avs_readdata <= fault_wide[31:0];
          `OFS_FAULT_HI: avs_readdata <= fault_wide[63:32];
          `OFS_STATUS: avs_readdata <= {25'h0000000, last_class, 2'b00,
                                        async_flag, sync_flag};
          default: avs_readdata <= 32'h00000000;
        endcase
      end
    end
  end

  // ========================================================================
  // Software-written configuration.
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl <= `CTRL_RESET;
      walk_attr <= `WALK_RESET;
    end else if (bus_done && avs_write && avs_byteenable[0]) begin
      if (word_addr == `OFS_CTRL) begin
        ctrl <= avs_writedata[7:0];
      end
      if (word_addr == `OFS_WALK_ATTR) begin
        walk_attr <= avs_writedata[5:0];
      end
    end
  end

  wire attr_global_en = ctrl[`CTRL_ATTR_EN];
  wire [ATTR_W-1:0] s1_attr_en = ctrl[`CTRL_S1_ATTR_EN_LO +: ATTR_W];
  wire [ATTR_W-1:0] s2_attr_en = ctrl[`CTRL_S2_ATTR_EN_LO +: ATTR_W];
  wire stage1_en = ctrl[`CTRL_STAGE1_EN];
  wire stage2_en = ctrl[`CTRL_STAGE2_EN];
  wire instr_cache_enable_bit = ctrl[`CTRL_ICACHE_EN];

  // ========================================================================
  // Memory attribute decode. A zero upper nibble marks Device memory; the
  // Device type sits in bits 3:2. Otherwise each nibble is an outer or inner
  // policy, and write-back is 11xx or 01xx other than 0100 (Non-cacheable).
  wire [3:0] outer_pol = xlat_mem_attr[7:4];
  wire [3:0] inner_pol = xlat_mem_attr[3:0];
  wire is_device = (outer_pol == 4'h0);
  wire outer_wb = (outer_pol[3:2] == 2'b11) ||
                  ((outer_pol[3:2] == 2'b01) && (outer_pol[1:0] != 2'b00));
  wire inner_wb = (inner_pol[3:2] == 2'b11) ||
                  ((inner_pol[3:2] == 2'b01) && (inner_pol[1:0] != 2'b00));
  wire cacheable = !is_device && outer_wb && inner_wb;
  wire translation_off = !stage1_en && !stage2_en;
  wire fetch_req = (xlat_requester == 1'b0);
  wire icache_only = translation_off && instr_cache_enable_bit && fetch_req;

  reg [1:0] dev_type;
  always @* begin
    case (inner_pol[3:2])
      2'b00: dev_type = `DEV_NGNRNE;
      2'b01: dev_type = `DEV_NGNRE;
      2'b10: dev_type = `DEV_NGRE;
      default: dev_type = `DEV_GRE;
    endcase
  end

  // A range fault caused only by a contiguous block reaching beyond the
  // input range is dropped; software mis-programming must not trap here.
  wire range_only = xlat_range_fault && contiguous_hint_bit;
  wire fault_kept = xlat_fault && !range_only;

  // ========================================================================
  // Translation response, one cycle after completion from the L1, L2 or walk source; source 3 gives none.
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      resp_valid <= 1'b0;
      resp_source <= `SRC_L1_HIT;
      resp_requester <= 1'b0;
      resp_pa <= {PA_W{1'b0}};
      resp_perm <= 4'h0;
      resp_ns <= 1'b0;
      resp_fault <= 1'b0;
      resp_fault_code <= 6'h00;
      resp_device <= 1'b0;
      resp_dev_type <= `DEV_NGNRNE;
      resp_cacheable <= 1'b0;
      resp_alloc_icache <= 1'b0;
      resp_alloc_unified <= 1'b0;
    end else begin
      resp_valid <= xlat_done && (xlat_source != 2'h3);
      if (xlat_done) begin
        resp_source <= xlat_source;
        resp_requester <= xlat_requester;
        resp_pa <= xlat_pa;
        resp_perm <= xlat_perm;
        resp_ns <= xlat_ns;
        resp_fault <= fault_kept;
        resp_fault_code <= fault_kept ? xlat_fault_code : 6'h00;
        resp_device <= is_device;
        resp_dev_type <= is_device ? dev_type : `DEV_NGNRNE;
        resp_cacheable <= cacheable;
        resp_alloc_icache <= icache_only || (cacheable && fetch_req);
        resp_alloc_unified <= cacheable && !icache_only;
      end
    end
  end

  // ========================================================================
  // Page attribute bits sent with each memory transaction. Aliased mappings
  // are not tracked: each transaction carries the bits of the mapping that
  // produced it, whichever that was.
  wire [ATTR_W-1:0] next_attr_bits;

  page_attr_merge #(
    .WIDTH(ATTR_W)
  ) u_attr_merge (
    .global_en(attr_global_en),
    .walk_access(mem_txn_walk),
    .walk_regime(mem_walk_regime),
    .hyp_walk_attr_ctrl(walk_attr[`WALK_HYP_LO +: ATTR_W]),
    .stage1_walk_attr_ctrl(walk_attr[`WALK_S1_LO +: ATTR_W]),
    .stage2_walk_attr_ctrl(walk_attr[`WALK_S2_LO +: ATTR_W]),
    .s1_en(stage1_en ? s1_attr_en : {ATTR_W{1'b0}}),
    .s2_en(stage2_en ? s2_attr_en : {ATTR_W{1'b0}}),
    .s1_bits(mem_s1_attr),
    .s2_bits(mem_s2_attr),
    .page_hw_attr_bits(next_attr_bits)
  );

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      mem_out_valid <= 1'b0;
      page_hw_attr_bits <= {ATTR_W{1'b0}};
    end else begin
      mem_out_valid <= mem_txn_valid;
      page_hw_attr_bits <= mem_txn_valid ? next_attr_bits : {ATTR_W{1'b0}};
    end
  end

  // ========================================================================
  // External abort classification.
  reg is_sync;
  always @* begin
    case (ext_abort_class)
      `ABT_WALK: is_sync = 1'b1;
      `ABT_LOAD: is_sync = !ext_abort_device;
      `ABT_LOAD_ACQ: is_sync = 1'b1;
      `ABT_ATOMIC: is_sync = 1'b1;
      default: is_sync = 1'b0;
    endcase
  end

  wire sync_event = ext_abort && is_sync;
  wire async_event = ext_abort && !is_sync;
  wire stat_clear = bus_done && avs_write && avs_byteenable[0] &&
                    (word_addr == `OFS_STATUS);
  wire next_sync_flag = sync_event ||
                        (sync_flag && !(stat_clear && avs_writedata[`STAT_SYNC]));
  wire next_async_flag = async_event ||
                         (async_flag && !(stat_clear && avs_writedata[`STAT_ASYNC]));

  // A new abort in the cycle of a clear keeps its flag set.
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      sync_abort <= 1'b0;
      async_abort <= 1'b0;
      sync_flag <= 1'b0;
      async_flag <= 1'b0;
      last_class <= `ABT_WALK;
      fault_addr <= {PA_W{1'b0}};
    end else begin
      sync_abort <= sync_event;
      async_abort <= async_event;
      sync_flag <= next_sync_flag;
      async_flag <= next_async_flag;
      if (ext_abort) begin
        last_class <= ext_abort_class;
      end
      if (sync_event) begin
        fault_addr <= ext_abort_addr;
      end
    end
  end

endmodule

//--- rtl/page_attr_merge.v
// Per-bit merge of stage 1 and stage 2 page hardware attribute bits.
`timescale 1ns/1ps
`include "mmu_attr_consts.vh"

module page_attr_merge #(
  parameter WIDTH = 2
) (
  input wire global_en,
  input wire walk_access,
  input wire [1:0] walk_regime,
  input wire [WIDTH-1:0] hyp_walk_attr_ctrl,
  input wire [WIDTH-1:0] stage1_walk_attr_ctrl,
  input wire [WIDTH-1:0] stage2_walk_attr_ctrl,
  input wire [WIDTH-1:0] s1_en,
  input wire [WIDTH-1:0] s2_en,
  input wire [WIDTH-1:0] s1_bits,
  input wire [WIDTH-1:0] s2_bits,
  output wire [WIDTH-1:0] page_hw_attr_bits
);

  reg [WIDTH-1:0] walk_bits;
  wire [WIDTH-1:0] merged;

  // ========================================================================
  // Walk accesses take their value from the walk control register of their regime; regime 3 gives zero.
  always @* begin
    case (walk_regime)
      `REGIME_HYP: walk_bits = hyp_walk_attr_ctrl;
      `REGIME_S1: walk_bits = stage1_walk_attr_ctrl;
      `REGIME_S2: walk_bits = stage2_walk_attr_ctrl;
      default: walk_bits = {WIDTH{1'b0}};
    endcase
  end

  // ========================================================================
  // Each bit has its own enables, so the stage choice is made bit by bit.
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      assign merged[i] = s2_en[i] ? s2_bits[i] : (s1_en[i] ? s1_bits[i] : 1'b0);
    end
  endgenerate

  assign page_hw_attr_bits = !global_en ? {WIDTH{1'b0}} :
                             (walk_access ? walk_bits : merged);
endmodule

//--- testbench/mmu_attr_monitor.sv
// Checker of translation response, abort routing and page attribute timing.
`timescale 1ns/1ps
module mmu_attr_monitor #(
  parameter PA_W = 48,
  parameter ATTR_W = 2
) (
  input wire clk,
  input wire reset,
  input wire xlat_done,
  input wire [1:0] xlat_source,
  input wire [PA_W-1:0] xlat_pa,
  input wire xlat_ns,
  input wire xlat_fault,
  input wire xlat_range_fault,
  input wire contiguous_hint_bit,
  input wire [7:0] xlat_mem_attr,
  input wire resp_valid,
  input wire [PA_W-1:0] resp_pa,
  input wire resp_ns,
  input wire resp_fault,
  input wire resp_device,
  input wire [1:0] resp_dev_type,
  input wire resp_cacheable,
  input wire mem_txn_valid,
  input wire mem_out_valid,
  input wire [ATTR_W-1:0] page_hw_attr_bits,
  input wire ext_abort,
  input wire [2:0] ext_abort_class,
  input wire ext_abort_device,
  input wire sync_abort,
  input wire async_abort
);
  // ==========================================================================
  // Decoded causes
  wire [7:0] m = xlat_mem_attr;
  wire wb_o = m[6] && (m[7] || m[5:4] != 2'h0);
  wire wb_i = m[2] && (m[3] || m[1:0] != 2'h0);
  wire is_sync = ext_abort_class == 3'h0 || ext_abort_class == 3'h2 || ext_abort_class == 3'h3
    || (ext_abort_class == 3'h1 && !ext_abort_device);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // ==========================================================================
  // Assertions
  a_resp_follows: assert property (xlat_done && xlat_source != 2'h3 |=> resp_valid)
    else $error("no response after a finished translation");
  a_resp_fields: assert property (xlat_done |=> resp_pa == $past(xlat_pa) && resp_ns == $past(xlat_ns))
    else $error("response address or security state wrong");
  a_fault_kept: assert property (xlat_done && xlat_fault && !xlat_range_fault |=> resp_fault)
    else $error("fault lost in response");
  a_sync_route: assert property (ext_abort && is_sync |=> sync_abort && !async_abort)
    else $error("abort not reported synchronously");
  a_async_route: assert property (ext_abort && !is_sync |=> async_abort && !sync_abort)
    else $error("abort not reported asynchronously");
  a_hint_nofault: assert property (xlat_done && contiguous_hint_bit && xlat_range_fault |=> !resp_fault)
    else $error("hinted block raised a range fault");
  a_dev_type: assert property (xlat_done && m[7:4] == 4'h0 |=> resp_device && resp_dev_type == $past(m[3:2]))
    else $error("device type wrong");
  a_cache_down: assert property (xlat_done |=> resp_cacheable == $past(wb_o && wb_i))
    else $error("cacheability wrong");
  a_attr_valid: assert property (mem_txn_valid |=> mem_out_valid)
    else $error("transaction lost its attribute beat");
  a_attr_idle: assert property (!mem_txn_valid |=> page_hw_attr_bits == '0 && !mem_out_valid)
    else $error("attribute bits driven without a transaction");
endmodule

bind mmu_response_attr_page_hw_attr_bits mmu_attr_monitor #(.PA_W(PA_W), .ATTR_W(ATTR_W)) u_mon (
  .clk(clk), .reset(reset), .xlat_done(xlat_done), .xlat_source(xlat_source),
  .xlat_pa(xlat_pa), .xlat_ns(xlat_ns), .xlat_fault(xlat_fault),
  .xlat_range_fault(xlat_range_fault), .contiguous_hint_bit(contiguous_hint_bit),
  .xlat_mem_attr(xlat_mem_attr), .resp_valid(resp_valid), .resp_pa(resp_pa), .resp_ns(resp_ns),
  .resp_fault(resp_fault), .resp_device(resp_device), .resp_dev_type(resp_dev_type),
  .resp_cacheable(resp_cacheable), .mem_txn_valid(mem_txn_valid), .mem_out_valid(mem_out_valid),
  .page_hw_attr_bits(page_hw_attr_bits), .ext_abort(ext_abort), .ext_abort_class(ext_abort_class),
  .ext_abort_device(ext_abort_device), .sync_abort(sync_abort), .async_abort(async_abort));

//--- testbench/mmu_response_attr_page_hw_attr_bits_tb.sv
// Self-checking bench for the MMU response, abort and page attribute block.
`timescale 1ns/1ps
`include "mmu_attr_consts.vh"
module mmu_response_attr_page_hw_attr_bits_tb;
  logic clk = 0, reset = 1, go = 0, avs_read = 0, avs_write = 0;
  logic [4:0] avs_address = 0;
  logic [31:0] avs_writedata = 0, rd;
  logic [3:0] avs_byteenable = 4'hf;
  logic [13:0] rq = 0;
  logic [1:0] rsp, mem_walk_regime = 0, mem_s1_attr = 0, mem_s2_attr = 0;
  logic mem_txn_valid = 0, mem_txn_walk = 0, ext_abort = 0, ext_abort_device = 0;
  logic [2:0] ext_abort_class = 0;
  logic [47:0] ext_abort_addr = 0;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, xlat_done, xlat_requester, xlat_ns, xlat_fault, xlat_range_fault;
  wire contiguous_hint_bit, resp_valid, resp_requester, resp_ns, resp_fault, resp_device;
  wire resp_cacheable, resp_alloc_icache, resp_alloc_unified, mem_out_valid, sync_abort, async_abort;
  wire [1:0] avs_response, xlat_source, resp_source, resp_dev_type, page_hw_attr_bits;
  wire [47:0] xlat_pa, resp_pa;
  wire [3:0] xlat_perm, resp_perm;
  wire [5:0] xlat_fault_code, resp_fault_code;
  wire [7:0] xlat_mem_attr;
  integer err_count = 0, n_tests = 0, cyc = 0, i;
  // Rows: source, {requester, fault, range, hint}, attributes, {valid, fault, device, type, cacheable}.
  logic [19:0] rows [0:9] = '{{2'h0, 4'h0, 8'hff, 6'h21}, {2'h1, 4'h8, 8'h44, 6'h20},
    {2'h2, 4'h8, 8'h00, 6'h28}, {2'h0, 4'h8, 8'h04, 6'h2a}, {2'h1, 4'h0, 8'h08, 6'h2c},
    {2'h2, 4'h0, 8'h0c, 6'h2e}, {2'h0, 4'h7, 8'hf4, 6'h20}, {2'h1, 4'h6, 8'h7f, 6'h31},
    {2'h2, 4'h5, 8'hc5, 6'h31}, {2'h3, 4'h0, 8'hff, 6'h01}};

  mmu_response_attr_page_hw_attr_bits #(.PA_W(48), .ATTR_W(2)) uut (
    .clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .xlat_done(xlat_done), .xlat_source(xlat_source),
    .xlat_requester(xlat_requester), .xlat_pa(xlat_pa), .xlat_perm(xlat_perm),
    .xlat_ns(xlat_ns), .xlat_fault(xlat_fault), .xlat_fault_code(xlat_fault_code),
    .xlat_range_fault(xlat_range_fault), .contiguous_hint_bit(contiguous_hint_bit),
    .xlat_mem_attr(xlat_mem_attr), .resp_valid(resp_valid), .resp_source(resp_source),
    .resp_requester(resp_requester), .resp_pa(resp_pa), .resp_perm(resp_perm),
    .resp_ns(resp_ns), .resp_fault(resp_fault), .resp_fault_code(resp_fault_code),
    .resp_device(resp_device), .resp_dev_type(resp_dev_type),
    .resp_cacheable(resp_cacheable), .resp_alloc_icache(resp_alloc_icache),
    .resp_alloc_unified(resp_alloc_unified), .mem_txn_valid(mem_txn_valid),
    .mem_txn_walk(mem_txn_walk), .mem_walk_regime(mem_walk_regime),
    .mem_s1_attr(mem_s1_attr), .mem_s2_attr(mem_s2_attr), .mem_out_valid(mem_out_valid),
    .page_hw_attr_bits(page_hw_attr_bits), .ext_abort(ext_abort),
    .ext_abort_class(ext_abort_class), .ext_abort_device(ext_abort_device),
    .ext_abort_addr(ext_abort_addr), .sync_abort(sync_abort), .async_abort(async_abort));
  xlat_requester_model mdl (
    .clk(clk), .go(go), .rq(rq), .xlat_done(xlat_done), .xlat_source(xlat_source),
    .xlat_requester(xlat_requester), .xlat_fault(xlat_fault),
    .xlat_range_fault(xlat_range_fault), .contiguous_hint_bit(contiguous_hint_bit),
    .xlat_mem_attr(xlat_mem_attr), .xlat_pa(xlat_pa), .xlat_perm(xlat_perm),
    .xlat_ns(xlat_ns), .xlat_fault_code(xlat_fault_code));

  initial forever #2 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count = err_count + 1;
      wrap_up;
    end
  end

  // ==========================================================================
  // Tasks
  task chk(input logic [47:0] got, input logic [47:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    integer k;
    k = 0;
    @(posedge clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do begin
      @(posedge clk);
      k = k + 1;
    end while (avs_waitrequest !== 1'b0 && k < 20);
    chk(k < 20, 1'b1);
    rd = avs_readdata;
    rsp = avs_response;
    avs_read <= 0;
    avs_write <= 0;
  endtask
  task rdchk(input logic [4:0] a, input logic [31:0] e);
    bus(0, a, 32'h0);
    chk({rsp, rd}, {`RESP_OKAY, e});
  endtask
  task xl(input logic [19:0] r);
    @(posedge clk);
    go <= 1;
    rq <= r[19:6];
    @(posedge clk);
    go <= 0;
    @(posedge clk);
    @(negedge clk);
  endtask
  task mt(input logic w, input logic [1:0] g, input logic [1:0] a1, a2, e);
    @(posedge clk);
    mem_txn_valid <= 1;
    mem_txn_walk <= w;
    mem_walk_regime <= g;
    mem_s1_attr <= a1;
    mem_s2_attr <= a2;
    @(posedge clk);
    mem_txn_valid <= 0;
    @(negedge clk);
    chk({mem_out_valid, page_hw_attr_bits}, {1'b1, e});
  endtask
  task wrap_up;
    $display("tests %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    reset <= 0;
    rdchk(`OFS_CTRL, 32'h0);
    rdchk(`OFS_WALK_ATTR, 32'h0);
    rdchk(`OFS_STATUS, 32'h0);
    bus(0, 5'h14, 32'h0);
    chk({rsp, rd}, {`RESP_DECODEERR, 32'h0});
    $display("test registers done");
    for (i = 0; i < 10; i = i + 1) begin
      xl(rows[i]);
      chk({resp_valid, resp_fault, resp_device, resp_dev_type, resp_cacheable}, rows[i][5:0]);
      chk(resp_pa, {rows[i][19:6], rows[i][19:6], rows[i][19:6], 6'h2a});
      chk(resp_fault_code, rows[i][4] ? rows[i][11:6] : 6'h00);
      chk({resp_source, resp_requester, resp_perm, resp_ns}, {rows[i][19:17], rows[i][13:10], rows[i][6]});
    end
    $display("test responses done");
    mt(0, 0, 2'h3, 2'h3, 2'h0);
    bus(1, `OFS_CTRL, 32'h73);
    mt(0, 0, 2'h3, 2'h0, 2'h1);
    mt(0, 0, 2'h0, 2'h3, 2'h2);
    bus(1, `OFS_CTRL, 32'h33);
    mt(0, 0, 2'h3, 2'h3, 2'h1);
    bus(1, `OFS_CTRL, 32'h1f);
    mt(0, 0, 2'h3, 2'h3, 2'h0);
    bus(1, `OFS_WALK_ATTR, 32'h27);
    mt(1, 0, 2'h0, 2'h0, 2'h3);
    mt(1, 1, 2'h3, 2'h3, 2'h1);
    mt(1, 2, 2'h0, 2'h0, 2'h2);
    mt(1, 3, 2'h3, 2'h3, 2'h0);
    $display("test page attributes done");
    bus(1, `OFS_CTRL, 32'h80);
    xl({2'h0, 4'h0, 8'hff, 6'h0});
    chk({resp_alloc_icache, resp_alloc_unified}, 2'b10);
    xl({2'h0, 4'h8, 8'hff, 6'h0});
    chk({resp_alloc_icache, resp_alloc_unified}, 2'b01);
    bus(1, `OFS_CTRL, 32'ha0);
    xl({2'h0, 4'h0, 8'hff, 6'h0});
    chk({resp_alloc_icache, resp_alloc_unified}, 2'b11);
    avs_byteenable <= 4'h0;
    bus(1, `OFS_CTRL, 32'h0);
    avs_byteenable <= 4'hf;
    rdchk(`OFS_CTRL, 32'ha0);
    $display("test allocation done");
    for (i = 0; i < 16; i = i + 1) begin
      @(posedge clk);
      ext_abort <= 1;
      ext_abort_class <= i[3:1];
      ext_abort_device <= i[0];
      ext_abort_addr <= {12{i[3:0]}};
      @(posedge clk);
      ext_abort <= 0;
      @(negedge clk);
      chk({sync_abort, async_abort}, (i < 8 && i != 3) ? 2'b10 : 2'b01);
    end
    rdchk(`OFS_FAULT_LO, 32'h77777777);
    rdchk(`OFS_FAULT_HI, 32'h00007777);
    bus(1, `OFS_FAULT_LO, 32'h0);
    rdchk(`OFS_FAULT_LO, 32'h77777777);
    rdchk(`OFS_STATUS, 32'h73);
    bus(1, `OFS_STATUS, 32'h1);
    rdchk(`OFS_STATUS, 32'h72);
    $display("test aborts done");
    @(posedge clk);
    reset <= 1;
    repeat (2) @(posedge clk);
    reset <= 0;
    rdchk(`OFS_CTRL, 32'h0);
    rdchk(`OFS_STATUS, 32'h0);
    $display("test second reset done");
    wrap_up;
  end
endmodule

//--- testbench/xlat_requester_model.sv
// Requester side model that issues one translation per request and then inverts its lines every idle cycle.
`timescale 1ns/1ps
module xlat_requester_model (
  input wire clk,
  input wire go,
  input wire [13:0] rq,
  output reg xlat_done = 1'b0,
  output wire [1:0] xlat_source,
  output wire xlat_requester,
  output wire xlat_fault,
  output wire xlat_range_fault,
  output wire contiguous_hint_bit,
  output wire [7:0] xlat_mem_attr,
  output wire [47:0] xlat_pa,
  output wire [3:0] xlat_perm,
  output wire xlat_ns,
  output wire [5:0] xlat_fault_code
);
  reg [72:0] f = 73'h0;
  assign {xlat_source, xlat_requester, xlat_fault, xlat_range_fault, contiguous_hint_bit,
    xlat_mem_attr, xlat_pa, xlat_perm, xlat_ns, xlat_fault_code} = f;
  // Idle lines toggle every cycle, so a design that samples them outside a request sees junk.
  always @(posedge clk) begin
    xlat_done <= go;
    f <= go ? {rq, rq, rq, rq, 6'h2a, rq[7:4], rq[0], rq[5:0]} : ~f;
  end
endmodule
